// *** shared/csar_pkg.sv ***
// Package for the CPU status and accumulator register block
`default_nettype none
package csar_pkg;
    localparam logic [7:0] ADDR_STATUS = 8'hd0;
    localparam logic [7:0] ADDR_ACCUMULATOR = 8'he0;
    localparam logic [7:0] ADDR_AUX = 8'hf0;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_FETCH_ADDR = 16'h0000;
    localparam int BIT_CARRY = 7;
    localparam int BIT_HALF_CARRY = 6;
    localparam int BIT_USER_ZERO = 5;
    localparam int BIT_BANK_HI = 4;
    localparam int BIT_BANK_LO = 3;
    localparam int BIT_OVERFLOW = 2;
    localparam int BIT_USER_ONE = 1;
    localparam int BIT_PARITY = 0;
    localparam logic [2:0] BANK_SHIFT = 3'h3;

    // Flag update strobes and values from the ALU
    typedef struct packed {
        logic carry_we;
        logic carry;
        logic half_carry_we;
        logic half_carry;
        logic overflow_we;
        logic overflow;
    } csar_flags_s;

    // Direct special-function register access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } csar_sfr_s;

    typedef struct packed {
        logic restart_done;
        logic [7:0] accumulator;
        logic [7:0] aux;
        logic carry_flag;
        logic half_carry_flag;
        logic user_flag_zero;
        logic [1:0] bank_select;
        logic overflow_flag;
        logic user_flag_one;
        logic [7:0] sfr_rdata;
        logic sfr_hit;
        logic [7:0] acc_out;
        logic [7:0] aux_out;
        logic [4:0] bank_base;
        logic parity_out;
        logic fetch_restart;
        logic [15:0] fetch_addr;
    } csar_state_s;
endpackage : csar_pkg
`default_nettype wire

// *** core/csar_regs.sv ***
// CPU accumulator, auxiliary and program status word registers
`default_nettype none
module csar_regs (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Special-function register access
    input wire csar_pkg::csar_sfr_s sfr_req,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // ALU datapath
    input wire logic alu_acc_we,
    input wire logic [7:0] alu_acc_data,
    input wire logic alu_aux_we,
    input wire logic [7:0] alu_aux_data,
    input wire csar_pkg::csar_flags_s alu_flags,
    // Values toward the datapath
    output logic [7:0] acc_value,
    output logic [7:0] aux_value,
    output logic [7:0] status_value,
    output logic [4:0] bank_base,
    output logic fetch_restart,
    output logic [15:0] fetch_addr
);
    csar_pkg::csar_state_s st;
    csar_pkg::csar_state_s next_st;
    // Reset release pipeline, kept apart from the state record
    logic [1:0] rst_sync;
    logic rst_int_n;
    // Address decode of the access port
    logic sel_status;
    logic sel_acc;
    logic sel_aux;
    logic wr_status;
    logic wr_acc;
    logic wr_aux;
    logic rd_mapped;
    logic [7:0] rd_word;
    logic [7:0] status_now;
    logic [7:0] next_acc_v;
    logic [7:0] next_aux_v;
    logic next_carry_v;
    logic next_half_v;
    logic next_user0_v;
    logic [1:0] next_bank_v;
    logic next_ovf_v;
    logic next_user1_v;

    assign rst_int_n = rst_sync[1];

    assign sel_status = sfr_req.addr == csar_pkg::ADDR_STATUS;
    assign sel_acc = sfr_req.addr == csar_pkg::ADDR_ACCUMULATOR;
    assign sel_aux = sfr_req.addr == csar_pkg::ADDR_AUX;
    assign wr_status = sfr_req.wr && sel_status;
    assign wr_acc = sfr_req.wr && sel_acc;
    assign wr_aux = sfr_req.wr && sel_aux;
    assign rd_mapped = sfr_req.rd && (sel_status || sel_acc || sel_aux);

    // Status byte with live parity from the held accumulator
    assign status_now = {st.carry_flag, st.half_carry_flag, st.user_flag_zero,
        st.bank_select, st.overflow_flag, st.user_flag_one, ^st.accumulator};

    // Read multiplexer; unmapped or idle reads return zero
    always_comb begin
        rd_word = csar_pkg::RESET_BYTE;
        if (sfr_req.rd) begin
            case (sfr_req.addr)
                csar_pkg::ADDR_STATUS: begin
                    rd_word = status_now;
                end
                csar_pkg::ADDR_ACCUMULATOR: begin
                    rd_word = st.accumulator;
                end
                csar_pkg::ADDR_AUX: begin
                    rd_word = st.aux;
                end
                default: begin
                    rd_word = csar_pkg::RESET_BYTE;
                end
            endcase
        end
    end

    // Accumulator and auxiliary: ALU path first, direct SFR write wins
    always_comb begin
        next_acc_v = st.accumulator;
        next_aux_v = st.aux;
        if (alu_acc_we) begin
            next_acc_v = alu_acc_data;
        end
        if (wr_acc) begin
            next_acc_v = sfr_req.wdata;
        end
        if (alu_aux_we) begin
            next_aux_v = alu_aux_data;
        end
        if (wr_aux) begin
            next_aux_v = sfr_req.wdata;
        end
    end

    // Status flags: software write first, ALU results win for their own flag
    always_comb begin
        next_carry_v = st.carry_flag;
        next_half_v = st.half_carry_flag;
        next_user0_v = st.user_flag_zero;
        next_bank_v = st.bank_select;
        next_ovf_v = st.overflow_flag;
        next_user1_v = st.user_flag_one;
        if (wr_status) begin
            next_carry_v = sfr_req.wdata[csar_pkg::BIT_CARRY];
            next_half_v = sfr_req.wdata[csar_pkg::BIT_HALF_CARRY];
            next_user0_v = sfr_req.wdata[csar_pkg::BIT_USER_ZERO];
            next_bank_v = sfr_req.wdata[csar_pkg::BIT_BANK_HI:csar_pkg::BIT_BANK_LO];
            next_ovf_v = sfr_req.wdata[csar_pkg::BIT_OVERFLOW];
            next_user1_v = sfr_req.wdata[csar_pkg::BIT_USER_ONE];
        end
        if (alu_flags.carry_we) begin
            next_carry_v = alu_flags.carry;
        end
        if (alu_flags.half_carry_we) begin
            next_half_v = alu_flags.half_carry;
        end
        if (alu_flags.overflow_we) begin
            next_ovf_v = alu_flags.overflow;
        end
    end

    always_comb begin
        next_st = st;
        next_st.accumulator = next_acc_v;
        next_st.aux = next_aux_v;
        next_st.carry_flag = next_carry_v;
        next_st.half_carry_flag = next_half_v;
        next_st.user_flag_zero = next_user0_v;
        next_st.bank_select = next_bank_v;
        next_st.overflow_flag = next_ovf_v;
        next_st.user_flag_one = next_user1_v;
        next_st.sfr_hit = rd_mapped;
        next_st.sfr_rdata = rd_word;
        next_st.acc_out = next_st.accumulator;
        next_st.aux_out = next_st.aux;
        next_st.parity_out = ^next_st.accumulator;
        next_st.bank_base = {next_st.bank_select, 3'h0};
        // One pulse on the first cycle out of reset
        next_st.restart_done = 1'b1;
        next_st.fetch_restart = !st.restart_done;
        next_st.fetch_addr = csar_pkg::RESET_FETCH_ADDR;
    end

    // Two stages before the internal reset lets go
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    always_ff @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            st.accumulator <= csar_pkg::RESET_BYTE;
            st.aux <= csar_pkg::RESET_BYTE;
            st.carry_flag <= 1'b0;
            st.half_carry_flag <= 1'b0;
            st.user_flag_zero <= 1'b0;
            st.bank_select <= 2'h0;
            st.overflow_flag <= 1'b0;
            st.user_flag_one <= 1'b0;
            st.sfr_rdata <= 8'h00;
            st.sfr_hit <= 1'b0;
            st.acc_out <= 8'h00;
            st.aux_out <= 8'h00;
            st.bank_base <= 5'h00;
            st.parity_out <= 1'b0;
            st.fetch_restart <= 1'b0;
            st.fetch_addr <= 16'h0000;
            st.restart_done <= 1'b0;
        end else begin
            st.accumulator <= next_st.accumulator;
            st.aux <= next_st.aux;
            st.carry_flag <= next_st.carry_flag;
            st.half_carry_flag <= next_st.half_carry_flag;
            st.user_flag_zero <= next_st.user_flag_zero;
            st.bank_select <= next_st.bank_select;
            st.overflow_flag <= next_st.overflow_flag;
            st.user_flag_one <= next_st.user_flag_one;
            st.sfr_rdata <= next_st.sfr_rdata;
            st.sfr_hit <= next_st.sfr_hit;
            st.acc_out <= next_st.acc_out;
            st.aux_out <= next_st.aux_out;
            st.bank_base <= next_st.bank_base;
            st.parity_out <= next_st.parity_out;
            st.fetch_restart <= next_st.fetch_restart;
            st.fetch_addr <= next_st.fetch_addr;
            st.restart_done <= next_st.restart_done;
        end
    end

    assign sfr_rdata = st.sfr_rdata;
    assign sfr_hit = st.sfr_hit;
    assign acc_value = st.acc_out;
    assign aux_value = st.aux_out;
    assign status_value = {st.carry_flag, st.half_carry_flag, st.user_flag_zero,
        st.bank_select, st.overflow_flag, st.user_flag_one, st.parity_out};
    assign bank_base = st.bank_base;
    assign fetch_restart = st.fetch_restart;
    assign fetch_addr = st.fetch_addr;
endmodule : csar_regs
`default_nettype wire

// *** dv/csar_alu_model.sv ***
// Adder standing in for the ALU datapath
`default_nettype none
module csar_alu_model (
    // Request from the bench
    input wire logic go,
    input wire logic [7:0] opnd,
    input wire logic [7:0] acc,
    // Toward the registers
    output logic acc_we,
    output logic [7:0] acc_data,
    output csar_pkg::csar_flags_s flags
);
    logic [8:0] sum;
    logic hc;
    logic ov;
    assign sum = {1'b0, acc} + {1'b0, opnd};
    assign hc = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]} > 5'h0f;
    assign ov = acc[7] == opnd[7] && sum[7] != acc[7];
    assign acc_we = go;
    assign acc_data = sum[7:0];
    assign flags = {go, sum[8], go, hc, go, ov};
endmodule : csar_alu_model
`default_nettype wire

// *** dv/csar_regs_properties.sv ***
// Port assertions for the status and accumulator registers
`default_nettype none
module csar_regs_properties (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Inputs watched
    input wire csar_pkg::csar_sfr_s sfr_req,
    input wire logic alu_acc_we,
    input wire logic [7:0] alu_acc_data,
    input wire csar_pkg::csar_flags_s alu_flags,
    // Outputs watched
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    input wire logic [7:0] acc_value,
    input wire logic [7:0] status_value,
    input wire logic [4:0] bank_base,
    input wire logic fetch_restart,
    input wire logic [15:0] fetch_addr
);
    logic wr_acc;
    logic rd_map;
    assign wr_acc = sfr_req.wr && sfr_req.addr == 8'he0;
    assign rd_map = sfr_req.addr inside {8'hd0, 8'he0, 8'hf0};
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    chk_parity_live: assert property (status_value[0] == ^acc_value)
        else $error("parity wrong");
    chk_read_acc: assert property (sfr_req.rd && sfr_req.addr == 8'he0
        |=> sfr_hit && sfr_rdata == $past(acc_value)) else $error("acc read wrong");
    chk_read_unmapped: assert property (sfr_req.rd && !rd_map
        |=> !sfr_hit && sfr_rdata == 8'h00) else $error("unmapped read answered");
    chk_acc_write: assert property (wr_acc |=> acc_value == $past(sfr_req.wdata))
        else $error("acc write lost");
    chk_alu_acc: assert property (alu_acc_we && !wr_acc
        |=> acc_value == $past(alu_acc_data)) else $error("alu result lost");
    chk_carry_flag: assert property (alu_flags.carry_we
        |=> status_value[7] == $past(alu_flags.carry)) else $error("carry wrong");
    chk_overflow_flag: assert property (alu_flags.overflow_we
        |=> status_value[2] == $past(alu_flags.overflow)) else $error("overflow wrong");
    chk_user_bits: assert property (sfr_req.wr && sfr_req.addr == 8'hd0
        |=> (status_value & 8'h3a) == ($past(sfr_req.wdata) & 8'h3a)) else $error("psw write");
    chk_bank_base: assert property (sfr_req.wr && sfr_req.addr == 8'hd0
        |=> bank_base == {$past(sfr_req.wdata[4:3]), 3'h0}) else $error("bank base wrong");
    chk_half_carry: assert property (alu_flags.half_carry_we
        |=> status_value[6] == $past(alu_flags.half_carry)) else $error("half carry wrong");
    chk_fetch_once: assert property (fetch_restart |=> !fetch_restart && fetch_addr == 16'h0000)
        else $error("fetch restart wrong");
    cover property (wr_acc && alu_acc_we);
    cover property (sfr_req.rd && !rd_map);
    cover property (fetch_restart);
    cover property (sfr_req.wr && sfr_req.addr == 8'hd0 && alu_flags.carry_we);
endmodule : csar_regs_properties
bind csar_regs csar_regs_properties u_props (.clk_sys(clk_sys), .rst_n(rst_n),
    .sfr_req(sfr_req), .alu_acc_we(alu_acc_we), .alu_acc_data(alu_acc_data),
    .alu_flags(alu_flags), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .acc_value(acc_value),
    .status_value(status_value), .bank_base(bank_base), .fetch_restart(fetch_restart),
    .fetch_addr(fetch_addr));
`default_nettype wire

// *** dv/csar_regs_test.sv ***
// Self-checking bench for the status and accumulator registers
`default_nettype none
module csar_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    csar_pkg::csar_sfr_s sfr_req = '0;
    logic alu_aux_we = 1'b0;
    logic [7:0] alu_aux_data = 8'h00;
    logic go = 1'b0;
    logic [7:0] opnd = 8'h00;
    logic alu_acc_we, sfr_hit, fetch_restart;
    logic [7:0] alu_acc_data, sfr_rdata, acc_value, aux_value, status_value;
    logic [4:0] bank_base;
    logic [15:0] fetch_addr;
    csar_pkg::csar_flags_s alu_flags;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int m_acc, m_aux, m_psw;
    csar_regs dut (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .sfr_hit(sfr_hit), .alu_acc_we(alu_acc_we), .alu_acc_data(alu_acc_data),
        .alu_aux_we(alu_aux_we), .alu_aux_data(alu_aux_data), .alu_flags(alu_flags),
        .acc_value(acc_value), .aux_value(aux_value), .status_value(status_value),
        .bank_base(bank_base), .fetch_restart(fetch_restart), .fetch_addr(fetch_addr));
    csar_alu_model alu (.go(go), .opnd(opnd), .acc(acc_value), .acc_we(alu_acc_we),
        .acc_data(alu_acc_data), .flags(alu_flags));
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 1000) begin
            n_errors++;
            conclude();
        end
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask : step
    function automatic logic [7:0] st();
        return {m_psw[7:1], ^m_acc[7:0]};
    endfunction : st
    function automatic logic [7:0] pick(input int n);
        logic [7:0] u = 8'($urandom);
        if (u inside {8'hd0, 8'he0, 8'hf0}) u = 8'h5b;
        return n % 4 == 0 ? 8'hd0 : n % 4 == 1 ? 8'he0 : n % 4 == 2 ? 8'hf0 : u;
    endfunction : pick
    task automatic chk_all();
        chk("acc", acc_value, m_acc[7:0]);
        chk("aux", aux_value, m_aux[7:0]);
        chk("status", status_value, st());
        chk("bank", bank_base, {m_psw[4:3], 3'h0});
    endtask : chk_all
    task automatic do_reset();
        int k;
        rst_n = 1'b0;
        sfr_req = '0;
        m_acc = 0;
        m_aux = 0;
        m_psw = 0;
        repeat (6) step();
        chk_all();
        rst_n = 1'b1;
        for (k = 0; k < 8 && fetch_restart !== 1'b1; k++) step();
        chk("restart", fetch_restart, 1'b1);
        chk("fetch", fetch_addr, 16'h0000);
        step();
        chk("restart_once", fetch_restart, 1'b0);
        $display("test reset done");
    endtask : do_reset
    // Write plus optional add in one cycle, then a read
    task automatic op(input logic [7:0] a, d, r, input logic add);
        int s;
        sfr_req = '{1'b1, 1'b0, a, d};
        go = add;
        opnd = 8'($urandom);
        alu_aux_we = a != 8'hf0 && 1'($urandom);
        alu_aux_data = 8'($urandom);
        s = m_acc + opnd;
        if (a == 8'hd0) m_psw = d;
        if (add) begin
            m_psw[7] = s > 255;
            m_psw[6] = m_acc % 16 + opnd % 16 > 15;
            m_psw[2] = ((m_acc ^ s) & (opnd ^ s) & 128) != 0;
        end
        m_acc = a == 8'he0 ? d : add ? s % 256 : m_acc;
        m_aux = a == 8'hf0 ? d : alu_aux_we ? alu_aux_data : m_aux;
        step();
        sfr_req = '{1'b0, 1'b1, r, 8'h00};
        go = 1'b0;
        alu_aux_we = 1'b0;
        step();
        chk("hit", sfr_hit, r inside {8'hd0, 8'he0, 8'hf0});
        chk("rdata", sfr_rdata, r == 8'hd0 ? st() : r == 8'he0 ? m_acc : r == 8'hf0 ? m_aux : 0);
        chk_all();
    endtask : op
    initial begin
        int i;
        void'($urandom(32'hd086));
        do_reset();
        for (i = 0; i < 40; i++) op(pick(i), 8'($urandom), pick($urandom), 1'($urandom));
        $display("test access done");
        op(8'he0, 8'hff, 8'he0, 1'b1);
        do_reset();
        conclude();
    end
endmodule : csar_regs_test
`default_nettype wire
